// ### src/cbu_branch_unit.sv
// conditional relative branch unit: condition test and pc update
//
// Summary of operation
// - equal on zero set, unequal on clear
// - carry-one on carry set, carry-zero on clear
// - unsigned pair tests carry, at-least on clear, below on set
// - negative on n set, nonnegative on clear
// - signed pair tests n xor v
// - half-carry pair tests the half-carry flag
// - transfer-bit pair tests the transfer flag
// - overflow pair tests the overflow flag
// - irq pair tests global interrupt enable
// - taken: pc becomes pc plus k plus one
// - one cycle not taken, two taken
`timescale 1ns/100ps
`default_nettype none

module cbu_branch_unit
    import cbu_pkg::*;
(
    // clock, reset, enable
    input  wire logic                i_ref_clk,
    input  wire logic                i_arst_n,
    input  wire logic                i_clk_en,
    // branch request from the decoder
    input  wire logic                i_issue,
    input  wire cbu_req_t            i_req,
    input  wire cbu_sreg_t           i_sreg,
    // program counter update
    output logic                     o_pc_load,
    output logic [CBU_PC_W-1:0]      o_pc_next,
    // completion
    output logic                     o_busy,
    output logic                     o_done,
    output logic                     o_taken,
    output logic                     o_illegal,
    // status register write strobe, never raised
    output logic                     o_sreg_wr
);

    // ************************************************************
    // condition test
    // ************************************************************

    logic cond_pass;
    logic cond_legal;

    cbu_cond_eval u_cond_eval (
        .i_cond  (i_req.cond),
        .i_sreg  (i_sreg),
        .o_pass  (cond_pass),
        .o_legal (cond_legal)
    );

    // ************************************************************
    // address arithmetic
    // ************************************************************

    logic [CBU_PC_W-1:0] disp_ext;
    logic [CBU_PC_W-1:0] seq_pc;
    logic [CBU_PC_W-1:0] tgt_pc;

    assign disp_ext = {{(CBU_PC_W-CBU_DISP_W){i_req.disp[CBU_DISP_W-1]}}, i_req.disp};

    // fall-through goes to the next word
    assign seq_pc = i_req.pc + CBU_PC_STEP;

    // target is pc plus k plus one, wrapping
    assign tgt_pc = seq_pc + disp_ext;

    // ************************************************************
    // sequencer
    // ************************************************************

    cbu_regs_t st_r;
    cbu_regs_t st_nxt;

    // next state; requests during the second cycle of a taken branch
    // are dropped, the decoder must hold off while busy is high
    always_comb begin
        st_nxt         = st_r;
        st_nxt.done    = 1'b0;
        st_nxt.pc_load = 1'b0;
        // flags are never written by a branch
        st_nxt.sreg_wr = 1'b0;
        unique case (st_r.state)
            CBU_ST_IDLE: begin
                if (i_issue) begin
                    st_nxt.illegal = ~cond_legal;
                    if (cond_pass) begin
                        // taken branch spends a second cycle
                        st_nxt.state   = CBU_ST_TAKEN;
                        st_nxt.busy    = 1'b1;
                        st_nxt.taken   = 1'b1;
                        st_nxt.pc_next = tgt_pc;
                    end else begin
                        // failed test completes in one cycle
                        st_nxt.done    = 1'b1;
                        st_nxt.pc_load = 1'b1;
                        st_nxt.taken   = 1'b0;
                        st_nxt.pc_next = seq_pc;
                    end
                end
            end
            CBU_ST_TAKEN: begin
                // load the stored target at the end of cycle two
                st_nxt.state   = CBU_ST_IDLE;
                st_nxt.busy    = 1'b0;
                st_nxt.done    = 1'b1;
                st_nxt.pc_load = 1'b1;
            end
        endcase
    end

    // registered state; enable low freezes everything
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st_r <= CBU_REGS_RST;
        end else if (i_clk_en) begin
            st_r <= st_nxt;
        end
    end

    // ************************************************************
    // outputs, straight from the state flops
    // ************************************************************

    assign o_pc_load = st_r.pc_load;
    assign o_pc_next = st_r.pc_next;
    assign o_busy    = st_r.busy;
    assign o_done    = st_r.done;
    assign o_taken   = st_r.taken;   // valid with done
    assign o_illegal = st_r.illegal; // unknown code, treated as not taken
    assign o_sreg_wr = st_r.sreg_wr;

endmodule : cbu_branch_unit

`default_nettype wire

// ### src/cbu_pkg.sv
// constants and types shared by the conditional branch unit
package cbu_pkg;

    // ************************************************************
    // widths
    // ************************************************************
    localparam int unsigned CBU_PC_W   = 16;
    localparam int unsigned CBU_DISP_W = 7;
    localparam int unsigned CBU_COND_W = 5;

    // sequential step added to the program counter (the "+1")
    localparam logic [CBU_PC_W-1:0] CBU_PC_STEP = 16'h0001;

    // cycle counts of a branch, not taken and taken
    localparam int unsigned CBU_CYC_NOT_TAKEN = 1;
    localparam int unsigned CBU_CYC_TAKEN     = 2;

    // ************************************************************
    // status flags, one bit each, bit 7 down to bit 0
    // ************************************************************
    typedef struct packed {
        logic irq_en;     // global interrupt enable
        logic transfer;   // transfer bit
        logic half_carry;
        logic sign;       // not used here, kept for layout
        logic overflow;
        logic negative;
        logic zero;
        logic carry;
    } cbu_sreg_t;

    // ************************************************************
    // branch variants
    // ************************************************************
    typedef enum logic [CBU_COND_W-1:0] {
        BRANCH_ON_EQUAL          = 5'h00,
        BRANCH_ON_UNEQUAL        = 5'h01,
        BRANCH_ON_CARRY_ONE      = 5'h02,
        BRANCH_ON_CARRY_ZERO     = 5'h03,
        BRANCH_UNSIGNED_AT_LEAST = 5'h04,
        BRANCH_UNSIGNED_BELOW    = 5'h05,
        BRANCH_ON_NEGATIVE       = 5'h06,
        BRANCH_ON_NONNEGATIVE    = 5'h07,
        BRANCH_SIGNED_AT_LEAST   = 5'h08,
        BRANCH_SIGNED_BELOW      = 5'h09,
        BRANCH_HALF_CARRY_ONE    = 5'h0A,
        BRANCH_HALF_CARRY_ZERO   = 5'h0B,
        BRANCH_TRANSFER_BIT_ONE  = 5'h0C,
        BRANCH_TRANSFER_BIT_ZERO = 5'h0D,
        BRANCH_OVERFLOW_ONE      = 5'h0E,
        BRANCH_OVERFLOW_ZERO     = 5'h0F,
        BRANCH_WHEN_IRQ_ON       = 5'h10,
        BRANCH_WHEN_IRQ_OFF      = 5'h11
    } cbu_cond_t;

    // one branch request as issued by the decoder
    typedef struct packed {
        cbu_cond_t                    cond;
        logic signed [CBU_DISP_W-1:0] disp;  // signed word offset
        logic [CBU_PC_W-1:0]          pc;    // address of the branch word
    } cbu_req_t;

    // ************************************************************
    // sequencer state
    // ************************************************************
    typedef enum logic [0:0] {
        CBU_ST_IDLE  = 1'b0,
        CBU_ST_TAKEN = 1'b1
    } cbu_state_t;

    typedef struct packed {
        cbu_state_t          state;
        logic [CBU_PC_W-1:0] pc_next;
        logic                pc_load;
        logic                taken;
        logic                done;
        logic                busy;
        logic                illegal;
        logic                sreg_wr;
    } cbu_regs_t;

    localparam cbu_regs_t CBU_REGS_RST = '{
        state:   CBU_ST_IDLE,
        pc_next: 16'h0000,
        pc_load: 1'b0,
        taken:   1'b0,
        done:    1'b0,
        busy:    1'b0,
        illegal: 1'b0,
        sreg_wr: 1'b0
    };

endpackage : cbu_pkg

// ### src/cbu_cond_eval.sv
// condition test for one branch variant against the status flags
`timescale 1ns/100ps
`default_nettype none

module cbu_cond_eval
    import cbu_pkg::*;
(
    // request
    input  wire logic [CBU_COND_W-1:0] i_cond,
    input  wire cbu_sreg_t             i_sreg,
    // result
    output logic                       o_pass,
    output logic                       o_legal
);

    // ************************************************************
    // flag selection
    // ************************************************************

    // picks the tested flag; variants come in pairs sharing one flag
    function automatic logic pick_flag(input logic [CBU_COND_W-1:0] c, input cbu_sreg_t s);
        logic f;
        f = 1'b0;
        unique case (c[CBU_COND_W-1:1])
            4'h0: f = s.zero;
            4'h1: f = s.carry;
            4'h2: f = s.carry;
            4'h3: f = s.negative;
            // signed compare uses n xor v
            4'h4: f = s.negative ^ s.overflow;
            4'h5: f = s.half_carry;
            4'h6: f = s.transfer;
            4'h7: f = s.overflow;
            4'h8: f = s.irq_en;
            default: f = 1'b0;
        endcase
        return f;
    endfunction : pick_flag

    // flag value that makes the branch go; the unsigned and signed
    // pairs list the "clear" case first, the rest the "set" case
    function automatic logic want_one(input logic [CBU_COND_W-1:0] c);
        logic w;
        w = 1'b0;
        unique case (c[CBU_COND_W-1:1])
            4'h2, 4'h4: w = c[0];
            default:    w = ~c[0];
        endcase
        return w;
    endfunction : want_one

    // codes above the last variant never pass
    always_comb begin
        o_legal = (i_cond <= BRANCH_WHEN_IRQ_OFF);
        o_pass  = o_legal && (pick_flag(i_cond, i_sreg) == want_one(i_cond));
    end

endmodule : cbu_cond_eval

`default_nettype wire

// ### bench/cbu_branch_unit_assertions.sv
// checker bound to the conditional branch unit ports
`timescale 1ns/100ps
`default_nettype none

module cbu_branch_unit_assertions
    import cbu_pkg::*;
(
    // clock, reset, enable
    input wire logic                i_ref_clk,
    input wire logic                i_arst_n,
    input wire logic                i_clk_en,
    // request side
    input wire logic                i_issue,
    input wire cbu_req_t            i_req,
    input wire cbu_sreg_t           i_sreg,
    // result side
    input wire logic                o_pc_load,
    input wire logic [CBU_PC_W-1:0] o_pc_next,
    input wire logic                o_busy,
    input wire logic                o_done,
    input wire logic                o_taken,
    input wire logic                o_illegal,
    input wire logic                o_sreg_wr
);
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_arst_n);
    logic acc;
    logic flag;
    logic want;
    // accepted request; issues during busy do not count
    assign acc = i_clk_en && i_issue && !o_busy;
    // reference test; pairs 2 and 4 read their flag inverted
    always_comb begin
        case (i_req.cond[4:1])
            4'h0: flag = i_sreg.zero;
            4'h1, 4'h2: flag = i_sreg.carry;
            4'h3: flag = i_sreg.negative;
            4'h4: flag = i_sreg.negative ^ i_sreg.overflow;
            4'h5: flag = i_sreg.half_carry;
            4'h6: flag = i_sreg.transfer;
            4'h7: flag = i_sreg.overflow;
            default: flag = i_sreg.irq_en;
        endcase
        want = flag ^ i_req.cond[0] ^ (i_req.cond[4:1] == 4'h2 || i_req.cond[4:1] == 4'h4);
    end
    // ************************************************************
    // properties
    // ************************************************************
    property p_cond;
        acc && i_req.cond <= 5'h11 |=> o_taken == $past(want);
    endproperty
    a_cond: assert property (p_cond) else $error("branch decision wrong");
    // explicit sign extension, so the offset never widens as unsigned
    property p_pc;
        acc |=> o_pc_next == $past(i_req.pc) + 16'h0001
                             + (o_taken ? $past({{9{i_req.disp[6]}}, i_req.disp}) : 16'h0000);
    endproperty
    a_pc: assert property (p_pc) else $error("new pc wrong");
    property p_one;
        acc |=> (o_taken ? (o_busy && !o_done) : (o_done && !o_busy));
    endproperty
    a_one: assert property (p_one) else $error("first cycle wrong");
    property p_two;
        o_busy && i_clk_en |=> o_done && !o_busy && $stable(o_pc_next);
    endproperty
    a_two: assert property (p_two) else $error("second cycle wrong");
    property p_pair;
        o_done == o_pc_load;
    endproperty
    a_pair: assert property (p_pair) else $error("load and done differ");
    property p_flags;
        !o_sreg_wr;
    endproperty
    a_flags: assert property (p_flags) else $error("flag write seen");
    property p_bad;
        acc && i_req.cond > 5'h11 |=> o_illegal && !o_taken && o_done;
    endproperty
    a_bad: assert property (p_bad) else $error("unknown code taken");
    property p_freeze;
        !i_clk_en |=> $stable(o_done) && $stable(o_pc_next);
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved while disabled");
endmodule : cbu_branch_unit_assertions

bind cbu_branch_unit cbu_branch_unit_assertions i_cbu_branch_unit_assertions (.*);

`default_nettype wire

// ### bench/cbu_branch_unit_tb_top.sv
// self-checking bench for the conditional branch unit
`timescale 1ns/100ps
`default_nettype none

module cbu_branch_unit_tb_top import cbu_pkg::*; ;
    typedef struct packed {
        logic [4:0] cond;
        logic [7:0] sreg;
        logic       taken;
    } cbu_row_t;
    // one code per row, flag set alone so a wrong flag shows, except n with v in rows[18]
    cbu_row_t rows [20] = '{
        '{5'h00, 8'h02, 1'h1}, '{5'h01, 8'h02, 1'h0}, '{5'h02, 8'h01, 1'h1}, '{5'h03, 8'h01, 1'h0},
        '{5'h04, 8'h01, 1'h0}, '{5'h05, 8'h01, 1'h1}, '{5'h06, 8'h04, 1'h1}, '{5'h07, 8'h04, 1'h0},
        '{5'h08, 8'h04, 1'h0}, '{5'h09, 8'h04, 1'h1}, '{5'h0A, 8'h20, 1'h1}, '{5'h0B, 8'h20, 1'h0},
        '{5'h0C, 8'h40, 1'h1}, '{5'h0D, 8'h40, 1'h0}, '{5'h0E, 8'h08, 1'h1}, '{5'h0F, 8'h08, 1'h0},
        '{5'h10, 8'h80, 1'h1}, '{5'h11, 8'h80, 1'h0}, '{5'h09, 8'h0C, 1'h0}, '{5'h08, 8'h10, 1'h1}};
    logic                i_ref_clk;
    logic                i_arst_n = 1'b0;
    logic                i_clk_en = 1'b1;
    logic                i_issue  = 1'b0;
    cbu_req_t            i_req    = '0;
    cbu_sreg_t           i_sreg   = '0;
    logic                o_pc_load, o_busy, o_done, o_taken, o_illegal, o_sreg_wr;
    logic [CBU_PC_W-1:0] o_pc_next;
    int                  err_count  = 0;
    int                  num_checks = 0;

    cbu_branch_unit i_cbu_branch_unit (.*);

    // status as one vector: busy, done, load, taken, illegal, flag write
    task automatic chk_st(input logic [5:0] exp);
        num_checks++;
        if ({o_busy, o_done, o_pc_load, o_taken, o_illegal, o_sreg_wr} !== exp) begin
            err_count++;
            $display("unexpected status at %0t: %0h vs %0h", $time,
                     {o_busy, o_done, o_pc_load, o_taken, o_illegal, o_sreg_wr}, exp);
        end
    endtask : chk_st
    task automatic chk_pc(input logic [15:0] exp);
        num_checks++;
        if (o_pc_next !== exp) begin
            err_count++;
            $display("unexpected pc at %0t: %0h vs %0h", $time, o_pc_next, exp);
        end
    endtask : chk_pc
    // inputs move one tick after the edge so sampling never races
    task automatic step;
        @(posedge i_ref_clk);
        #1;
    endtask : step
    task automatic set(input logic [4:0] c, input logic [7:0] s, input logic [6:0] d, input logic [15:0] pc);
        i_req.cond = cbu_cond_t'(c);
        i_req.disp = d;
        i_req.pc   = pc;
        i_sreg     = s;
        i_issue    = 1'b1;
    endtask : set
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : wrap_up

    initial begin
        i_ref_clk = 1'b0;
        forever #5 i_ref_clk = ~i_ref_clk;
    end
    // watchdog: the whole run needs about 660 ns
    initial begin
        #20000;
        err_count++;
        wrap_up();
    end

    initial begin
        logic [6:0]  d;
        logic [15:0] pc;
        #12;
        chk_st(6'h00);
        chk_pc(16'h0000);
        // reset spans the edges at 5, 15 and 25 ns
        repeat (2) @(posedge i_ref_clk);
        #1;
        i_arst_n = 1'b1;
        $display("reset test finished");
        // table: every legal code, signed pair twice, pc near the top to force wrap
        for (int i = 0; i < 20; i++) begin
            d  = i[0] ? 7'h40 : 7'h3F;
            pc = 16'hFFFC + 16'(i) * 16'h0C01;
            step();
            set(rows[i].cond, rows[i].sreg, d, pc);
            step();
            i_issue = 1'b0;
            chk_st(rows[i].taken ? 6'h24 : 6'h18);
            chk_pc(pc + (rows[i].taken ? {{9{d[6]}}, d} : 16'h0000) + 16'h0001);
            if (rows[i].taken) begin
                step();
                chk_st(6'h1C);
            end
        end
        $display("table test finished");
        // back to back not taken: one answer per cycle
        set(5'h00, 8'h00, 7'h05, 16'h0100);
        step();
        set(5'h01, 8'h02, 7'h05, 16'h0200);
        chk_pc(16'h0101);
        step();
        i_issue = 1'b0;
        chk_st(6'h18);
        chk_pc(16'h0201);
        $display("back to back test finished");
        // taken with most negative offset, issue held through busy
        set(5'h00, 8'h02, 7'h40, 16'h1000);
        step();
        set(5'h02, 8'h01, 7'h01, 16'h2000);
        step();
        chk_st(6'h1C);
        chk_pc(16'h0FC1);
        i_issue = 1'b0;
        step();
        chk_st(6'h04);
        $display("busy refusal test finished");
        // unknown code, then a stretched pulse while disabled
        set(5'h15, 8'hFF, 7'h10, 16'h3000);
        step();
        i_issue  = 1'b0;
        i_clk_en = 1'b0;
        chk_st(6'h1A);
        chk_pc(16'h3001);
        step();
        chk_st(6'h1A);
        i_clk_en = 1'b1;
        step();
        chk_st(6'h02);
        $display("unknown code test finished");
        // taken branch frozen in its second cycle, then reset mid-run
        set(5'h10, 8'h80, 7'h02, 16'h4000);
        step();
        i_issue  = 1'b0;
        i_clk_en = 1'b0;
        chk_st(6'h24);
        step();
        chk_st(6'h24);
        i_clk_en = 1'b1;
        step();
        chk_st(6'h1C);
        chk_pc(16'h4003);
        i_arst_n = 1'b0;
        step();
        chk_st(6'h00);
        chk_pc(16'h0000);
        // first request lands on the first edge after release
        i_arst_n = 1'b1;
        set(5'h0E, 8'h00, 7'h7F, 16'h5000);
        step();
        i_issue = 1'b0;
        chk_st(6'h18);
        chk_pc(16'h5001);
        $display("stall and reset test finished");
        wrap_up();
    end
endmodule : cbu_branch_unit_tb_top

`default_nettype wire
